// >>> src/gmod_addr_gen.sv
// indirect address generator for one auxiliary register access
`timescale 1ns/1ps
`include "gmod_consts.svh"
module gmod_addr_gen
    import gmod_pkg::*;
(
    // modification request
    input wire logic [4:0] mod_code,
    input wire logic [23:0] aux_base_reg,
    input wire logic [7:0] disp,
    input wire logic [23:0] index_reg_first,
    input wire logic [23:0] index_reg_second,
    // results
    output logic [23:0] eff_addr,
    output logic [23:0] new_base,
    output logic base_write,
    output logic circ_update,
    output logic bitrev_update,
    output logic mod_illegal
);
    gmod_ofs_e ofs_sel;
    logic [23:0] ofs;
    logic [23:0] moved;

    // offset source follows the two top bits of the code
    always_comb begin
        ofs_sel = gmod_ofs_e'(mod_code[4:3]);
        unique case (ofs_sel)
            GMOD_OFS_DISP: ofs = {16'h0000, disp}; // [RULE7]
            GMOD_OFS_INDEX_FIRST: ofs = index_reg_first; // [RULE15]
            GMOD_OFS_INDEX_SECOND: ofs = index_reg_second; // [RULE16]
            // special codes only ever add the first index register
            GMOD_OFS_SPECIAL: ofs = index_reg_first;
        endcase
        moved = mod_code[0] ? aux_base_reg - ofs : aux_base_reg + ofs;
    end

    // pre forms address the moved value, post forms address the base
    always_comb begin
        eff_addr = aux_base_reg;
        new_base = aux_base_reg;
        base_write = 1'b0;
        circ_update = 1'b0;
        bitrev_update = 1'b0;
        mod_illegal = 1'b0;
        if (mod_code[4:3] != 2'h3) begin
            unique case (mod_code[2:1])
                2'h0: eff_addr = moved; // [RULE7]
                2'h1: begin
                    eff_addr = moved; // [RULE7]
                    new_base = moved;
                    base_write = 1'b1;
                end
                2'h2: begin
                    new_base = moved; // [RULE8]
                    base_write = 1'b1;
                end
                2'h3: begin
                    // modular wrap lives in the buffer unit outside
                    new_base = moved; // [RULE9]
                    base_write = 1'b1;
                    circ_update = 1'b1;
                end
            endcase
        end else if (mod_code == 5'h19) begin
            new_base = aux_base_reg + index_reg_first;
            base_write = 1'b1;
            bitrev_update = 1'b1;
        end else if (mod_code != 5'h18) begin
            mod_illegal = 1'b1;
        end
    end
endmodule : gmod_addr_gen

// >>> src/gmod_consts.svh
// constants for the general mode operand decoder
// What this block does
// RULE1: top three bits zero mark a general addressing class word.
// RULE2: bits 22 and 21 select how the low sixteen bits are read.
// RULE3: mode 00 register, 01 direct, 10 indirect, 11 immediate.
// RULE4: indirect base is any of eight auxiliary registers, zero to seven.
// RULE5: register fields carry a cpu register address from the map.
// RULE6: four encoding groups: general, three-operand, parallel, branch.
// RULE7: codes 00000-00011 address base plus/minus displacement; codes 00010/00011 update base.
// RULE8: codes 00100/00101 address base, then base becomes base plus/minus displacement.
// RULE9: codes 00110/00111 address base, then circular update by displacement.
// RULE10: float pair multiplies op1 by op2, and adds or subtracts op4/op5.
// RULE11: integer pair multiplies op1 by op2 and adds op4 and op5.
// RULE12: integer pair multiplies op1 by op2 and subtracts op5 from op4.
// RULE13: of op1, op2, op4, op5 exactly two are registers, two indirect.
// RULE14: first parallel destination is R0-R7; second is restricted indirect.
// RULE15: codes 01000-01111 mirror displacement codes using first index register.
// RULE16: codes 10000-10111 mirror displacement codes using second index register.
// RULE17: opcode 28-23, dst 20-16, src 4-0, mod 15-11, aux 10-8, disp 7-0.
`ifndef GMOD_CONSTS_SVH
`define GMOD_CONSTS_SVH
`define GMOD_CLASS_HI 31
`define GMOD_CLASS_LO 29
`define GMOD_MODE_HI 22
`define GMOD_MODE_LO 21
`define GMOD_OPC_HI 28
`define GMOD_OPC_LO 23
`define GMOD_DST_HI 20
`define GMOD_DST_LO 16
`define GMOD_SRC_HI 4
`define GMOD_SRC_LO 0
`define GMOD_PAD_HI 15
`define GMOD_PAD_LO 5
`define GMOD_MODF_HI 15
`define GMOD_MODF_LO 11
`define GMOD_AUX_HI 10
`define GMOD_AUX_LO 8
`define GMOD_DISP_HI 7
`define GMOD_DISP_LO 0
`define GMOD_FIRST_REG_MAX 5'h07
`define GMOD_AR_BASE 5'h08
`define GMOD_ADDR_RST 24'h000000
`endif

// >>> src/gmod_decoder.sv
// general mode operand decoder with auxiliary register file
`timescale 1ns/1ps
`include "gmod_consts.svh"
module gmod_decoder
    import gmod_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // instruction in
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    // index registers from the core
    input wire logic [23:0] index_reg_first,
    input wire logic [23:0] index_reg_second,
    // parallel multiply pair request
    input wire logic par_valid,
    input wire logic par_float,
    input wire logic par_subtract,
    input wire logic op1_is_reg,
    input wire logic op2_is_reg,
    input wire logic op4_is_reg,
    input wire logic op5_is_reg,
    input wire logic [4:0] par_first_dst,
    input wire logic [4:0] par_second_mod,
    // decoded general instruction
    output logic dec_valid,
    output gmod_group_e dec_group,
    output logic dec_general,
    output gmod_mode_e dec_mode,
    output logic [5:0] dec_opcode,
    output logic [4:0] dec_dst_reg,
    output logic [4:0] dec_src_reg,
    output logic [15:0] dec_direct,
    output logic [15:0] dec_immediate,
    output logic [23:0] dec_eff_addr,
    output logic dec_circ,
    output logic dec_bitrev,
    output logic dec_error,
    // auxiliary register view
    output logic [23:0] aux_base_reg [8],
    // decoded parallel pair
    output logic par_dec_valid,
    output gmod_pair_e par_kind,
    output logic par_mul_float,
    output logic par_mul_int,
    output logic par_addsub_sub,
    output logic par_ok
);
    logic [23:0] next_aux [8];
    logic [2:0] aux_sel;
    logic [4:0] mod_code;
    logic [23:0] ag_addr;
    logic [23:0] ag_base;
    logic ag_write;
    logic ag_circ;
    logic ag_bitrev;
    logic ag_illegal;
    logic pc_ok;
    logic is_general;
    gmod_mode_e mode;

    logic next_dec_valid;
    gmod_group_e next_dec_group;
    logic next_dec_general;
    gmod_mode_e next_dec_mode;
    logic [5:0] next_dec_opcode;
    logic [4:0] next_dec_dst_reg;
    logic [4:0] next_dec_src_reg;
    logic [15:0] next_dec_direct;
    logic [15:0] next_dec_immediate;
    logic [23:0] next_dec_eff_addr;
    logic next_dec_circ;
    logic next_dec_bitrev;
    logic next_dec_error;
    logic next_par_dec_valid;
    gmod_pair_e next_par_kind;
    logic next_par_mul_float;
    logic next_par_mul_int;
    logic next_par_addsub_sub;
    logic next_par_ok;

    // group from the top three bits; 000 is general, 001 three-operand
    function automatic gmod_group_e group_of(input logic [2:0] top);
        if (top == 3'h0) begin
            group_of = GMOD_GRP_GENERAL;
        end else if (top == 3'h1) begin
            group_of = GMOD_GRP_THREE;
        end else if (top[2:1] == 2'h1) begin
            group_of = GMOD_GRP_BRANCH;
        end else begin
            group_of = GMOD_GRP_PARALLEL;
        end
    endfunction : group_of

    // field extraction for the general class
    always_comb begin
        is_general = (instr[`GMOD_CLASS_HI:`GMOD_CLASS_LO] == 3'h0); // [RULE1]
        mode = gmod_mode_e'(instr[`GMOD_MODE_HI:`GMOD_MODE_LO]); // [RULE2]
        aux_sel = instr[`GMOD_AUX_HI:`GMOD_AUX_LO]; // [RULE4]
        mod_code = instr[`GMOD_MODF_HI:`GMOD_MODF_LO];
    end

    gmod_addr_gen u_addr_gen (
        .mod_code(mod_code),
        .aux_base_reg(aux_base_reg[aux_sel]),
        .disp(instr[`GMOD_DISP_HI:`GMOD_DISP_LO]),
        .index_reg_first(index_reg_first),
        .index_reg_second(index_reg_second),
        .eff_addr(ag_addr),
        .new_base(ag_base),
        .base_write(ag_write),
        .circ_update(ag_circ),
        .bitrev_update(ag_bitrev),
        .mod_illegal(ag_illegal)
    );

    gmod_par_check u_par_check (
        .op1_is_reg(op1_is_reg),
        .op2_is_reg(op2_is_reg),
        .op4_is_reg(op4_is_reg),
        .op5_is_reg(op5_is_reg),
        .first_dst(par_first_dst),
        .second_mod(par_second_mod),
        .placement_ok(pc_ok)
    );

    // next decode values; decoded fields hold between valid words, dec_valid, dec_circ, dec_bitrev and dec_error drop
    always_comb begin
        next_dec_valid = instr_valid;
        next_dec_group = dec_group;
        next_dec_general = dec_general;
        next_dec_mode = dec_mode;
        next_dec_opcode = dec_opcode;
        next_dec_dst_reg = dec_dst_reg;
        next_dec_src_reg = dec_src_reg;
        next_dec_direct = dec_direct;
        next_dec_immediate = dec_immediate;
        next_dec_eff_addr = dec_eff_addr;
        next_dec_circ = 1'b0;
        next_dec_bitrev = 1'b0;
        next_dec_error = 1'b0;
        next_aux = aux_base_reg;
        if (instr_valid) begin
            next_dec_group = group_of(instr[31:29]); // [RULE6]
            next_dec_general = is_general;
            next_dec_mode = mode;
            next_dec_opcode = instr[`GMOD_OPC_HI:`GMOD_OPC_LO];
            next_dec_dst_reg = instr[`GMOD_DST_HI:`GMOD_DST_LO]; // [RULE5]
            next_dec_src_reg = 5'h00;
            next_dec_direct = 16'h0000;
            next_dec_immediate = 16'h0000;
            next_dec_eff_addr = `GMOD_ADDR_RST;
            if (is_general) begin
                unique case (mode) // [RULE3]
                    GMOD_SRC_REG: begin
                        next_dec_src_reg = instr[`GMOD_SRC_HI:`GMOD_SRC_LO];
                        // nonzero padding is a malformed word [RULE17]
                        next_dec_error =
                            (instr[`GMOD_PAD_HI:`GMOD_PAD_LO] != 11'h000);
                    end
                    GMOD_SRC_DIRECT: next_dec_direct = instr[15:0];
                    GMOD_SRC_INDIRECT: begin
                        next_dec_eff_addr = ag_addr;
                        next_dec_circ = ag_circ;
                        next_dec_bitrev = ag_bitrev;
                        next_dec_error = ag_illegal;
                        // a refused code leaves the base untouched
                        if (ag_write && !ag_illegal) begin
                            next_aux[aux_sel] = ag_base; // [RULE4]
                        end
                    end
                    GMOD_SRC_IMMEDIATE: next_dec_immediate = instr[15:0];
                endcase
            end
        end
    end

    // parallel pair decode: multiply op1*op2, add or subtract op4/op5
    always_comb begin
        next_par_dec_valid = par_valid;
        next_par_kind = par_kind;
        next_par_mul_float = par_mul_float;
        next_par_mul_int = par_mul_int;
        next_par_addsub_sub = par_addsub_sub;
        next_par_ok = par_ok;
        if (par_valid) begin
            next_par_kind = par_float ? GMOD_PAIR_FLOAT : GMOD_PAIR_INT;
            next_par_mul_float = par_float; // [RULE10]
            next_par_mul_int = !par_float; // [RULE11]
            // subtract form is op4 minus op5 for both kinds
            next_par_addsub_sub = par_subtract; // [RULE12]
            next_par_ok = pc_ok; // [RULE13] [RULE14]
        end
    end

    // register stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dec_valid <= 1'b0;
            dec_group <= GMOD_GRP_GENERAL;
            dec_general <= 1'b0;
            dec_mode <= GMOD_SRC_REG;
            dec_opcode <= 6'h00;
            dec_dst_reg <= 5'h00;
            dec_src_reg <= 5'h00;
            dec_direct <= 16'h0000;
            dec_immediate <= 16'h0000;
            dec_eff_addr <= `GMOD_ADDR_RST;
            dec_circ <= 1'b0;
            dec_bitrev <= 1'b0;
            dec_error <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                aux_base_reg[i] <= `GMOD_ADDR_RST;
            end
            par_dec_valid <= 1'b0;
            par_kind <= GMOD_PAIR_NONE;
            par_mul_float <= 1'b0;
            par_mul_int <= 1'b0;
            par_addsub_sub <= 1'b0;
            par_ok <= 1'b0;
        end else begin
            dec_valid <= next_dec_valid;
            dec_group <= next_dec_group;
            dec_general <= next_dec_general;
            dec_mode <= next_dec_mode;
            dec_opcode <= next_dec_opcode;
            dec_dst_reg <= next_dec_dst_reg;
            dec_src_reg <= next_dec_src_reg;
            dec_direct <= next_dec_direct;
            dec_immediate <= next_dec_immediate;
            dec_eff_addr <= next_dec_eff_addr;
            dec_circ <= next_dec_circ;
            dec_bitrev <= next_dec_bitrev;
            dec_error <= next_dec_error;
            aux_base_reg <= next_aux;
            par_dec_valid <= next_par_dec_valid;
            par_kind <= next_par_kind;
            par_mul_float <= next_par_mul_float;
            par_mul_int <= next_par_mul_int;
            par_addsub_sub <= next_par_addsub_sub;
            par_ok <= next_par_ok;
        end
    end
endmodule : gmod_decoder

// >>> src/gmod_par_check.sv
// operand placement check for parallel multiply pairs
`timescale 1ns/1ps
`include "gmod_consts.svh"
module gmod_par_check (
    // operand kinds, high means register address
    input wire logic op1_is_reg,
    input wire logic op2_is_reg,
    input wire logic op4_is_reg,
    input wire logic op5_is_reg,
    // destinations
    input wire logic [4:0] first_dst,
    input wire logic [4:0] second_mod,
    // verdict
    output logic placement_ok
);
    logic [2:0] reg_count;
    logic mod_ok;

    // exactly two register operands, two indirect
    always_comb begin
        reg_count = {2'h0, op1_is_reg} + {2'h0, op2_is_reg}
            + {2'h0, op4_is_reg} + {2'h0, op5_is_reg}; // [RULE13]
        // second destination may use codes 00000-10111 and 11000
        mod_ok = (second_mod[4:3] != 2'h3) || (second_mod == 5'h18);
        placement_ok = (reg_count == 3'h2)
            && (first_dst <= `GMOD_FIRST_REG_MAX) && mod_ok; // [RULE14]
    end
endmodule : gmod_par_check

// >>> src/gmod_pkg.sv
// types for the general mode operand decoder
package gmod_pkg;
    typedef enum logic [1:0] {
        GMOD_GRP_GENERAL = 2'h0,
        GMOD_GRP_THREE = 2'h1,
        GMOD_GRP_PARALLEL = 2'h2,
        GMOD_GRP_BRANCH = 2'h3
    } gmod_group_e;
    typedef enum logic [1:0] {
        GMOD_SRC_REG = 2'h0,
        GMOD_SRC_DIRECT = 2'h1,
        GMOD_SRC_INDIRECT = 2'h2,
        GMOD_SRC_IMMEDIATE = 2'h3
    } gmod_mode_e;
    typedef enum logic [1:0] {
        GMOD_OFS_DISP = 2'h0,
        GMOD_OFS_INDEX_FIRST = 2'h1,
        GMOD_OFS_INDEX_SECOND = 2'h2,
        GMOD_OFS_SPECIAL = 2'h3
    } gmod_ofs_e;
    typedef enum logic [1:0] {
        GMOD_PAIR_NONE = 2'h0,
        GMOD_PAIR_FLOAT = 2'h1,
        GMOD_PAIR_INT = 2'h2
    } gmod_pair_e;
endpackage : gmod_pkg

// >>> tb/gmod_sva.sv
// assertion checker for the general mode operand decoder
`timescale 1ns/1ps
module gmod_sva
    import gmod_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // requests
    input wire logic instr_valid,
    input wire logic [31:0] instr,
    input wire logic par_valid,
    input wire logic par_float,
    input wire logic par_subtract,
    // decoded results
    input wire logic dec_valid,
    input wire logic dec_general,
    input wire gmod_mode_e dec_mode,
    input wire logic [4:0] dec_src_reg,
    input wire logic dec_error,
    input wire logic dec_circ,
    input wire logic par_dec_valid,
    input wire logic par_mul_float,
    input wire logic par_mul_int,
    input wire logic par_addsub_sub
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // general word in register mode with a clean pad
    sequence s_reg_word;
        instr_valid && instr[31:29] == 3'h0 && instr[22:21] == 2'h0
            && instr[15:5] == 11'h000;
    endsequence
    // indirect word asking for a circular update
    sequence s_circ_word;
        instr_valid && instr[31:29] == 3'h0 && instr[22:21] == 2'h2
            && instr[13:12] == 2'h3 && instr[15:14] != 2'h3;
    endsequence
    a_valid_pulse: assert property (instr_valid |=> dec_valid)
        else $error("no dec_valid after taken word");
    a_class_flag: assert property (instr_valid |=>
        dec_general == ($past(instr[31:29]) == 3'h0))
        else $error("dec_general wrong");
    a_mode_field: assert property (
        instr_valid && instr[31:29] == 3'h0 |=>
        dec_mode == $past(instr[22:21]))
        else $error("dec_mode wrong");
    a_mode_hold: assert property (!instr_valid |=> $stable(dec_mode))
        else $error("dec_mode moved without a word");
    a_src_reg: assert property (s_reg_word |=>
        dec_src_reg == $past(instr[4:0]) && !dec_error)
        else $error("register source wrong");
    a_circ_flag: assert property (s_circ_word |=> dec_circ)
        else $error("circular flag missing");
    a_par_pulse: assert property (par_valid |=> par_dec_valid)
        else $error("no par_dec_valid");
    a_par_kind: assert property (par_valid |=>
        par_mul_float == $past(par_float) && par_mul_int == !$past(par_float))
        else $error("pair kind wrong");
    a_par_sub: assert property (
        par_valid |=> par_addsub_sub == $past(par_subtract))
        else $error("add or subtract form wrong");
endmodule : gmod_sva

bind gmod_decoder gmod_sva gmod_sva_i (.clk(clk), .arst_n(arst_n),
    .instr_valid(instr_valid), .instr(instr), .par_valid(par_valid),
    .par_float(par_float), .par_subtract(par_subtract),
    .dec_valid(dec_valid), .dec_general(dec_general), .dec_mode(dec_mode),
    .dec_src_reg(dec_src_reg), .dec_error(dec_error), .dec_circ(dec_circ),
    .par_dec_valid(par_dec_valid), .par_mul_float(par_mul_float),
    .par_mul_int(par_mul_int), .par_addsub_sub(par_addsub_sub));

// >>> tb/tb_top.sv
// self-checking bench for the general mode operand decoder
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
    import gmod_pkg::*;
    logic clk, arst_n, instr_valid, par_valid, par_float, par_subtract;
    logic op1_is_reg, op2_is_reg, op4_is_reg, op5_is_reg;
    logic [31:0] instr;
    logic [23:0] index_reg_first, index_reg_second, dec_eff_addr;
    logic [4:0] par_first_dst, par_second_mod, dec_dst_reg, dec_src_reg;
    logic dec_valid, dec_general, dec_circ, dec_bitrev, dec_error;
    logic par_dec_valid, par_mul_float, par_mul_int, par_addsub_sub, par_ok;
    gmod_group_e dec_group;
    gmod_mode_e dec_mode;
    gmod_pair_e par_kind;
    logic [5:0] dec_opcode;
    logic [15:0] dec_direct, dec_immediate;
    logic [23:0] aux_base_reg [8];
    logic [23:0] ar [8];
    int n_fail, compares;

    gmod_decoder gmod_decoder_i (.clk(clk), .arst_n(arst_n),
        .instr_valid(instr_valid), .instr(instr),
        .index_reg_first(index_reg_first), .index_reg_second(index_reg_second),
        .par_valid(par_valid), .par_float(par_float),
        .par_subtract(par_subtract), .op1_is_reg(op1_is_reg),
        .op2_is_reg(op2_is_reg), .op4_is_reg(op4_is_reg),
        .op5_is_reg(op5_is_reg), .par_first_dst(par_first_dst),
        .par_second_mod(par_second_mod), .dec_valid(dec_valid),
        .dec_group(dec_group), .dec_general(dec_general),
        .dec_mode(dec_mode), .dec_opcode(dec_opcode),
        .dec_dst_reg(dec_dst_reg), .dec_src_reg(dec_src_reg),
        .dec_direct(dec_direct), .dec_immediate(dec_immediate),
        .dec_eff_addr(dec_eff_addr), .dec_circ(dec_circ),
        .dec_bitrev(dec_bitrev), .dec_error(dec_error),
        .aux_base_reg(aux_base_reg), .par_dec_valid(par_dec_valid),
        .par_kind(par_kind), .par_mul_float(par_mul_float),
        .par_mul_int(par_mul_int), .par_addsub_sub(par_addsub_sub),
        .par_ok(par_ok));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task close_out;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    // one word, answer lands one edge later; valid dropped before checking
    task send(input logic [31:0] w);
        @(posedge clk);
        #2;
        instr = w;
        instr_valid = 1'b1;
        @(posedge clk);
        #2;
        instr_valid = 1'b0;
        `CHK(dec_valid, 1'b1)
    endtask : send

    task t_modes;
        for (int m = 0; m < 4; m++) begin
            send({3'h0, 6'h2A, m[1:0], 5'h13, 16'h0005});
            `CHK(dec_mode, m[1:0])
            `CHK(dec_opcode, 6'h2A)
            `CHK(dec_dst_reg, 5'h13)
            `CHK(dec_src_reg, (m == 0) ? 5'h05 : 5'h00)
            `CHK(dec_direct, (m == 1) ? 16'h0005 : 16'h0000)
            `CHK(dec_immediate, (m == 3) ? 16'h0005 : 16'h0000)
            `CHK(dec_eff_addr, (m == 2) ? 24'h000005 : 24'h000000)
        end
        $display("done modes");
    endtask : t_modes

    task t_groups;
        gmod_group_e g;
        for (int t = 0; t < 8; t++) begin
            g = (t == 0) ? GMOD_GRP_GENERAL : (t == 1) ? GMOD_GRP_THREE
                : (t < 4) ? GMOD_GRP_BRANCH : GMOD_GRP_PARALLEL;
            send({t[2:0], 29'h0});
            `CHK(dec_group, g)
            `CHK(dec_general, t == 0)
        end
        $display("done groups");
    endtask : t_groups

    // modification codes 00000-11001 in turn, base updates carried to the next word on the same register
    task t_ind;
        logic [23:0] o, s, ea, nb;
        logic [4:0] c;
        logic [7:0] d;
        logic [2:0] n;
        for (int k = 0; k < 26; k++) begin
            c = k[4:0];
            n = 3'(k + 3);
            d = 8'h10 + {3'h0, c};
            o = (c[4:3] == 2'h0) ? {16'h0, d}
                : (c[4:3] == 2'h2) ? index_reg_second : index_reg_first;
            s = (c[0] && k != 25) ? ar[n] - o : ar[n] + o;
            ea = (c[2] || c[4:3] == 2'h3) ? ar[n] : s;
            nb = ((c[2:1] != 2'h0 && c[4:3] != 2'h3) || k == 25) ? s : ar[n];
            send({16'h0040, c, n, d});
            `CHK(dec_eff_addr, ea)
            `CHK(aux_base_reg[n], nb)
            `CHK(dec_circ, c[2:1] == 2'h3 && c[4:3] != 2'h3)
            `CHK(dec_bitrev, k == 25)
            ar[n] = nb;
        end
        $display("done indirect");
    endtask : t_ind

    task t_err;
        send(32'h0000_0025);
        `CHK(dec_error, 1'b1)
        send({16'h0040, 5'h1A, 3'h2, 8'h04});
        `CHK(dec_error, 1'b1)
        `CHK(aux_base_reg[2], ar[2])
        $display("done errors");
    endtask : t_err

    task par(input logic f, s, input logic [3:0] r,
             input logic [4:0] d, m, input logic ok);
        @(posedge clk);
        #2;
        par_float = f;
        par_subtract = s;
        {op1_is_reg, op2_is_reg, op4_is_reg, op5_is_reg} = r;
        par_first_dst = d;
        par_second_mod = m;
        par_valid = 1'b1;
        @(posedge clk);
        #2;
        par_valid = 1'b0;
        `CHK(par_dec_valid, 1'b1)
        `CHK(par_kind, f ? GMOD_PAIR_FLOAT : GMOD_PAIR_INT)
        `CHK(par_mul_float, f)
        `CHK(par_mul_int, !f)
        `CHK(par_addsub_sub, s)
        `CHK(par_ok, ok)
    endtask : par

    task t_par;
        for (int i = 0; i < 4; i++) begin
            par(i[1], i[0], 4'hC, 5'h07, 5'h00, 1'b1);
        end
        par(1'b0, 1'b0, 4'h5, 5'h00, 5'h18, 1'b1);
        par(1'b0, 1'b0, 4'hE, 5'h00, 5'h00, 1'b0);
        par(1'b0, 1'b1, 4'h3, 5'h08, 5'h00, 1'b0);
        par(1'b1, 1'b0, 4'h9, 5'h00, 5'h19, 1'b0);
        par(1'b1, 1'b1, 4'h6, 5'h01, 5'h17, 1'b1);
        $display("done parallel");
    endtask : t_par

    // guard against a hung run
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        close_out();
    end

    initial begin
        {clk, instr_valid, par_valid, par_float, par_subtract} = 5'h00;
        {op1_is_reg, op2_is_reg, op4_is_reg, op5_is_reg} = 4'h0;
        arst_n = 1'b0;
        instr = 32'h0;
        index_reg_first = 24'h000123;
        index_reg_second = 24'hFF0456;
        par_first_dst = 5'h00;
        par_second_mod = 5'h00;
        n_fail = 0;
        compares = 0;
        foreach (ar[i]) ar[i] = 24'h000000;
        repeat (4) @(posedge clk);
        #2;
        arst_n = 1'b1;
        `CHK(par_kind, GMOD_PAIR_NONE)
        `CHK(aux_base_reg[7], 24'h000000)
        t_modes();
        t_groups();
        t_ind();
        t_err();
        t_par();
        close_out();
    end
endmodule : tb_top
